//--- verilog/adc_seq_defines.svh
// Register offsets, field positions, reset values and counts of the sequencer.
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define OFS_STATE 12'h000
`define OFS_CTL_ONE 12'h004
`define OFS_CTL_TWO 12'h008
`define OFS_TIMING 12'h00c
`define OFS_SLOT_ZERO 12'h010
`define OFS_SLOT_THREE 12'h01c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ST_EOC 0
`define ST_BUSY 1
`define ST_OVF 2
`define ST_PTR_LO 4
`define C1_ON 0
`define C1_IRQ 2
`define C2_START 7
`define C2_SCAN_LO 5
`define C2_REPEAT 4
`define TM_DELAY_LO 3

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define PTR_RESET 2'h3
`define CONV_TICKS 4'ha
`define DIV_MAX_CODE 3'h5
`define DELAY_MAX_CODE 3'h6
`define SCAN_FOUR 2'h1

`endif

//--- verilog/adc_seq_pkg.sv
// Types shared by the conversion sequencer.
package adc_seq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETTLE = 2'b01,
        ST_CONVERT = 2'b11,
        ST_STORE = 2'b10
    } seq_state_e;

    typedef logic [7:0] byte_t;

endpackage

//--- verilog/adc_conversion_sequencer.sv
// APB-controlled conversion sequencer of an 8-bit analog-to-digital converter.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "adc_seq_defines.svh"

module adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    input wire logic CORE_CLK, // System clock, 125 MHz.
    input wire logic RESET_N, // Asynchronous reset, active low.
    input wire logic PSEL, // APB select.
    input wire logic PENABLE, // APB access phase.
    input wire logic PWRITE, // APB direction, high for write.
    input wire logic [11:0] PADDR, // APB byte address.
    input wire logic [31:0] PWDATA, // APB write data.
    input wire logic [3:0] PSTRB, // APB write byte strobes.
    output logic [31:0] PRDATA, // APB read data.
    output logic PREADY, // APB ready, always high.
    output logic PSLVERR, // APB error for unmapped access or a write without byte strobe 0.
    input wire logic [7:0] ADC_RESULT, // Result from the analog core.
    output logic ADC_POWER, // Analog core power enable.
    output logic [2:0] ADC_CHANNEL, // Selected analog input.
    output logic ADC_SAMPLE, // One-cycle pulse: sample the input.
    output logic ADC_TICK, // One-cycle converter clock tick.
    output logic ADC_IRQ // Interrupt request, level.
);

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    byte_t ctl_one;
    byte_t ctl_two;
    byte_t timing;
    byte_t slot [4];
    logic [3:0] slot_full;
    logic [1:0] ptr;
    logic eoc;
    logic ovf;
    logic irq_pend;
    seq_state_e state;
    logic [4:0] div_cnt;
    logic [6:0] tick_cnt;
    logic [1:0] scan_idx;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    logic is_slot;
    logic on;
    logic start;
    logic scan_four;
    logic tick;
    logic last_conv;
    logic start_wr;
    logic start_rise;
    logic stop;
    logic [4:0] div_top;
    logic [6:0] delay_top;

    assign setup = PSEL & ~PENABLE;
    assign access = PSEL & PENABLE;
    assign is_slot = PADDR[11:4] == 8'h01 && PADDR[1:0] == 2'h0;
    assign mapped = PADDR <= `OFS_TIMING && PADDR[1:0] == 2'h0 || is_slot;
    assign wr = access & PWRITE & mapped & PSTRB[0];
    assign rd = access & ~PWRITE & mapped;
    assign PREADY = 1'b1;
    assign PSLVERR = access & ~(mapped & (~PWRITE | PSTRB[0]));

    assign on = ctl_one[`C1_ON];
    assign start = ctl_two[`C2_START];
    assign scan_four = ctl_two[`C2_SCAN_LO +: 2] == `SCAN_FOUR;

    // Factor as 2 to the power of the code, with the code capped at top.
    function automatic logic [6:0] pow2(input logic [2:0] code,
                                        input logic [2:0] top);
        logic [2:0] c;
        c = (code > top) ? top : code;
        pow2 = 7'h01 << c;
    endfunction

    assign div_top = 5'(pow2(timing[2:0], `DIV_MAX_CODE) - 7'h01);
    assign delay_top = pow2(timing[`TM_DELAY_LO +: 3], `DELAY_MAX_CODE)
        - 7'h01;
    assign tick = state != ST_IDLE && div_cnt == div_top;
    assign start_wr = wr && PADDR == `OFS_CTL_TWO;
    assign start_rise = start_wr & PWDATA[`C2_START] & ~start & on;
    assign stop = ~on | (start_wr & ~PWDATA[`C2_START]);
    assign last_conv = ~scan_four | scan_idx == 2'h3;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl_one <= 8'h00;
            timing <= 8'h00;
        end else if (wr) begin
            if (PADDR == `OFS_CTL_ONE) begin
                ctl_one <= PWDATA[7:0] & 8'h05;
            end
            if (PADDR == `OFS_TIMING) begin
                timing <= PWDATA[7:0] & 8'h3f;
            end
        end
    end

    // Mode and channel are taken by any write made while on with the start bit clear, with or without a start; writes while off are dropped.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl_two <= 8'h00;
        end else if (~on) begin
            ctl_two[`C2_START] <= 1'b0;
        end else if (start_wr) begin
            if (~start) begin
                ctl_two <= PWDATA[7:0] & {on, 7'h3f};
            end else begin
                ctl_two[`C2_START] <= PWDATA[`C2_START];
            end
        end else if (state == ST_STORE && last_conv &&
                     ~ctl_two[`C2_REPEAT]) begin
            ctl_two[`C2_START] <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Converter clock divider
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_cnt <= 5'h00;
        end else if (state == ST_IDLE || tick) begin
            div_cnt <= 5'h00;
        end else begin
            div_cnt <= div_cnt + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= ST_IDLE;
            tick_cnt <= 7'h00;
            scan_idx <= 2'h0;
        end else if (stop) begin
            state <= ST_IDLE;
            tick_cnt <= 7'h00;
            scan_idx <= 2'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    tick_cnt <= 7'h00;
                    scan_idx <= 2'h0;
                    if (start_rise) begin
                        state <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (tick) begin
                        if (tick_cnt == delay_top) begin
                            tick_cnt <= 7'h00;
                            state <= ST_CONVERT;
                        end else begin
                            tick_cnt <= tick_cnt + 7'h01;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (tick) begin
                        if (tick_cnt == 7'(`CONV_TICKS - 4'h1)) begin
                            tick_cnt <= 7'h00;
                            state <= ST_STORE;
                        end else begin
                            tick_cnt <= tick_cnt + 7'h01;
                        end
                    end
                end
                ST_STORE: begin
                    scan_idx <= last_conv ? 2'h0 : scan_idx + 2'h1;
                    if (last_conv && ~ctl_two[`C2_REPEAT]) begin
                        state <= ST_IDLE;
                    end else begin
                        state <= ST_SETTLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Result slots, pointer and flags
    // ------------------------------------------------------------------
    logic store;
    logic slot_rd;
    logic [1:0] next_ptr;

    assign store = state == ST_STORE && ~stop;
    assign slot_rd = rd & is_slot;
    assign next_ptr = ptr + 2'h1;

    always_ff @(posedge CORE_CLK) begin
        if (store) begin
            slot[next_ptr] <= ADC_RESULT;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ptr <= `PTR_RESET;
            slot_full <= 4'h0;
        end else if (start_rise) begin
            ptr <= `PTR_RESET;
            slot_full <= 4'h0;
        end else begin
            if (store) begin
                ptr <= next_ptr;
            end
            for (int i = 0; i < 4; i++) begin
                if (store && next_ptr == 2'(i)) begin
                    slot_full[i] <= 1'b1;
                end else if (slot_rd && PADDR[3:2] == 2'(i)) begin
                    slot_full[i] <= 1'b0;
                end
            end
        end
    end

    // Set wins over a slot-read clear in the same cycle; switching off wins over both.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            eoc <= 1'b0;
            irq_pend <= 1'b0;
        end else if (~on) begin
            eoc <= 1'b0;
            irq_pend <= 1'b0;
        end else if (store && last_conv) begin
            eoc <= 1'b1;
            irq_pend <= 1'b1;
        end else if (slot_rd) begin
            eoc <= 1'b0;
            irq_pend <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ovf <= 1'b0;
        end else if (~on) begin
            ovf <= 1'b0;
        end else if (store && slot_full[next_ptr]) begin
            ovf <= 1'b1;
        end else if (wr && PADDR == `OFS_STATE && PWDATA[`ST_OVF]) begin
            ovf <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read data, captured in the setup phase
    // ------------------------------------------------------------------
    byte_t next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        case (PADDR)
            `OFS_STATE: begin
                next_rdata[`ST_EOC] = eoc;
                next_rdata[`ST_BUSY] = state != ST_IDLE;
                next_rdata[`ST_OVF] = ovf;
                next_rdata[`ST_PTR_LO +: 2] = ptr;
            end
            `OFS_CTL_ONE: begin
                next_rdata = ctl_one;
            end
            `OFS_CTL_TWO: begin
                next_rdata = ctl_two;
            end
            `OFS_TIMING: begin
                next_rdata = timing;
            end
            default: begin
                if (is_slot) begin
                    next_rdata = slot[PADDR[3:2]];
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (setup) begin
            PRDATA <= {24'h00_0000, next_rdata};
        end
    end

    // ------------------------------------------------------------------
    // Analog core side
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ADC_CHANNEL <= 3'h0;
            ADC_SAMPLE <= 1'b0;
            ADC_TICK <= 1'b0;
            ADC_IRQ <= 1'b0;
            ADC_POWER <= 1'b0;
        end else begin
            ADC_CHANNEL <= scan_four ? {ctl_two[2], scan_idx}
                                     : ctl_two[2:0];
            ADC_SAMPLE <= state == ST_SETTLE && tick &&
                tick_cnt == delay_top && ~stop;
            ADC_TICK <= tick;
            ADC_IRQ <= irq_pend & ctl_one[`C1_IRQ] & on;
            ADC_POWER <= on;
        end
    end

endmodule

//--- tb/analog_core_model.sv
// Behavioural analog core that answers each sample with a channel code.
`timescale 1ns/10ps

module analog_core_model (
    input wire logic clk, // System clock.
    input wire logic power, // Core powered.
    input wire logic [2:0] channel, // Selected input.
    input wire logic sample, // Sample strobe.
    output logic [7:0] result // Converted value.
);
    logic [7:0] held = 8'h00;

    // Unpowered, the inverse shows so that stale data never matches.
    assign result = power ? held : ~held;

    always @(posedge clk) begin
        if (sample) begin
            held <= {channel, 5'h0b};
        end
    end
endmodule

//--- tb/adc_seq_assertions.sv
// Concurrent checks on the ports of the conversion sequencer.
`timescale 1ns/10ps
`include "adc_seq_defines.svh"

module adc_seq_checker (
    input wire logic CORE_CLK, // Clock.
    input wire logic RESET_N, // Reset, active low.
    input wire logic PSEL, // Select.
    input wire logic PENABLE, // Access phase.
    input wire logic PWRITE, // Direction.
    input wire logic [11:0] PADDR, // Address.
    input wire logic [31:0] PWDATA, // Write data.
    input wire logic [3:0] PSTRB, // Strobes.
    input wire logic [31:0] PRDATA, // Read data.
    input wire logic PREADY, // Ready.
    input wire logic PSLVERR, // Error.
    input wire logic ADC_POWER, // Analog power.
    input wire logic ADC_SAMPLE, // Sample pulse.
    input wire logic ADC_TICK, // Converter tick.
    input wire logic ADC_IRQ // Interrupt.
);
    logic acc;
    logic irq_allow;
    logic [3:0] ticks;

    assign acc = PSEL && PENABLE;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_allow <= 1'b0;
        end else if (acc && PWRITE && PSTRB[0] && PADDR == `OFS_CTL_ONE) begin
            irq_allow <= PWDATA[`C1_IRQ];
        end
    end

    // Counts converter ticks since the last sample, saturating at 15.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ticks <= 4'hf;
        end else if (ADC_SAMPLE) begin
            ticks <= 4'h0;
        end else if (acc && PWRITE && PADDR == `OFS_CTL_TWO) begin
            ticks <= 4'hf;
        end else if (ADC_TICK && ticks != 4'hf) begin
            ticks <= ticks + 4'h1;
        end
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence slot_read_s;
        acc && !PWRITE && PADDR >= `OFS_SLOT_ZERO && PADDR <= `OFS_SLOT_THREE;
    endsequence
    sequence off_write_s;
        acc && PWRITE && PSTRB[0] && PADDR == `OFS_CTL_ONE && !PWDATA[0];
    endsequence

    ready_always_a: assert property (PREADY)
        else $error("ready low");
    upper_zero_a: assert property (acc && !PWRITE |-> PRDATA[31:8] == 0)
        else $error("upper read bits set");
    narrow_err_a: assert property (acc && PWRITE && !PSTRB[0] |-> PSLVERR)
        else $error("narrow write accepted");
    unmapped_err_a: assert property (acc && PADDR > 12'h01c |-> PSLVERR)
        else $error("unmapped access accepted");
    irq_gated_a: assert property (ADC_IRQ |-> $past(irq_allow))
        else $error("irq without allow");
    irq_power_a: assert property (ADC_IRQ |-> ADC_POWER)
        else $error("irq while off");
    read_clear_a: assert property (slot_read_s |=> ##1 !ADC_IRQ)
        else $error("irq kept after slot read");
    off_stops_a: assert property (off_write_s |-> ##2 !ADC_POWER [*4])
        else $error("power kept after off");
    ten_ticks_a: assert property (ADC_SAMPLE |-> ticks >= 4'ha)
        else $error("conversion shorter than ten ticks");
endmodule

bind adc_conversion_sequencer adc_seq_checker adc_seq_checker_i (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ADC_POWER(ADC_POWER), .ADC_SAMPLE(ADC_SAMPLE), .ADC_TICK(ADC_TICK),
    .ADC_IRQ(ADC_IRQ));

//--- tb/testbench.sv
// Self-checking bench for the conversion sequencer over APB.
`timescale 1ns/10ps
`include "adc_seq_defines.svh"

module testbench;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, power, sample, tick, irq, err;
    logic [7:0] result;
    logic [2:0] channel;
    int num_errors = 0;
    int comparisons = 0;
    int gap = 0;
    int gap_seen = 0;
    int ticks_to_sample = 0;
    int settle_seen = 0;

    always #4 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        gap <= tick ? 1 : gap + 1;
        if (tick) begin
            gap_seen <= gap;
        end
        if (sample || !power) begin
            ticks_to_sample <= 0;
        end else if (tick) begin
            ticks_to_sample <= ticks_to_sample + 1;
        end
        if (sample) begin
            settle_seen <= ticks_to_sample + 1;
        end
    end

    adc_conversion_sequencer adc_conversion_sequencer_i (
        .CORE_CLK(core_clk), .RESET_N(reset_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .ADC_RESULT(result), .ADC_POWER(power), .ADC_CHANNEL(channel),
        .ADC_SAMPLE(sample), .ADC_TICK(tick), .ADC_IRQ(irq));

    analog_core_model analog_core_model_i (.clk(core_clk), .power(power),
        .channel(channel), .sample(sample), .result(result));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("%0d errors in %0d comparisons", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d, input logic [3:0] s);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'h1);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 8'h00, 4'h0);
    endtask

    task automatic wait_done;
        int n = 0;
        rd(`OFS_STATE);
        while (rdata[`ST_EOC] !== 1'b1 && n < 1000) begin
            rd(`OFS_STATE);
            n++;
        end
        if (rdata[`ST_EOC] !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: done never set", $time);
        end
    endtask

    task automatic power_up(input logic [7:0] tm, input logic [7:0] c1);
        wr(`OFS_CTL_ONE, 8'h00);
        wr(`OFS_TIMING, tm);
        wr(`OFS_CTL_ONE, c1);
        repeat (12500) @(posedge core_clk);
    endtask

    initial begin
        repeat (90000) @(posedge core_clk);
        num_errors++;
        $display("unexpected at %0t: run hung", $time);
        give_verdict;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(12'(4 * i));
            check(rdata, (i == 0) ? 32'h30 : 32'h0);
        end
        rd(12'h020);
        check({31'h0, err}, 32'h1);
        check(rdata, 32'h0);
        apb(1'b1, `OFS_TIMING, 8'h2d, 4'h2);
        check({31'h0, err}, 32'h1);
        rd(`OFS_TIMING);
        check(rdata, 32'h0);
        for (int c = 0; c < 6; c++) begin
            power_up({2'h0, 3'(5 - c), 3'(c)}, {5'h0, 1'(c), 2'b01});
            wr(`OFS_CTL_TWO, {5'b10000, 3'(c)});
            wait_done;
            check(rdata, 32'h01);
            check(32'(gap_seen), 32'(1 << c));
            check(32'(settle_seen), 32'(1 << (5 - c)));
            check({31'h0, irq}, 32'(c % 2));
            rd(`OFS_CTL_TWO);
            check(rdata, {29'h0, 3'(c)});
            rd(`OFS_SLOT_ZERO);
            check(rdata, {24'h0, 3'(c), 5'h0b});
            rd(`OFS_STATE);
            check(rdata, 32'h0);
            check({31'h0, irq}, 32'h0);
        end
        wr(`OFS_CTL_TWO, 8'ha4);
        wait_done;
        check(rdata, 32'h31);
        rd(`OFS_CTL_TWO);
        check(rdata, 32'h24);
        for (int i = 0; i < 4; i++) begin
            rd(`OFS_SLOT_ZERO + 12'(4 * i));
            check(rdata, {24'h0, 3'(4 + i), 5'h0b});
        end
        wr(`OFS_CTL_TWO, 8'hb4);
        wait_done;
        rd(`OFS_SLOT_ZERO);
        wait_done;
        check(rdata, 32'h37);
        wr(`OFS_CTL_TWO, 8'h34);
        wr(`OFS_STATE, 8'h04);
        rd(`OFS_SLOT_ZERO);
        rd(`OFS_STATE);
        check(rdata, 32'h30);
        wr(`OFS_CTL_TWO, 8'h91);
        wait_done;
        rd(`OFS_CTL_TWO);
        check(rdata, 32'h91);
        wr(`OFS_CTL_TWO, 8'h00);
        repeat (400) @(posedge core_clk);
        rd(`OFS_STATE);
        check({31'h0, rdata[`ST_BUSY]}, 32'h0);
        wr(`OFS_CTL_TWO, 8'h91);
        repeat (100) @(posedge core_clk);
        wr(`OFS_CTL_ONE, 8'h04);
        rd(`OFS_STATE);
        check(rdata & 32'h07, 32'h0);
        rd(`OFS_CTL_TWO);
        check(rdata, 32'h11);
        check({31'h0, power}, 32'h0);
        give_verdict;
    end
endmodule
